// ==== common/rwsm_map.svh ====
// Register indices, field positions, reset values and timing figures of the reset unit.
// Assumes byte address = 4 * register index on a 32-bit APB bus.
`ifndef RWSM_MAP_SVH
`define RWSM_MAP_SVH
`define RWSM_IDX_TIMER_ADC_CLK_CFG    8'h94
`define RWSM_IDX_AUX_IRQ_FLAGS        8'h95
`define RWSM_IDX_SOFT_COMMAND         8'h97
`define RWSM_IDX_UNDERVOLT_DETECT_CTL 8'hbf
`define RWSM_IDX_SUPPLY_MONITOR_CTRL  8'he3
`define RWSM_IDX_WATCHDOG_POWER_CTRL  8'hf7
`define RWSM_IDX_AUX_STROBE_CTRL      8'hf8
`define RWSM_WDT_PSC_LSB        4
`define RWSM_UVD_FLAG_BIT       7
`define RWSM_SLEEP_POR_DIS_BIT  6
`define RWSM_POR_DIS_BIT        5
`define RWSM_UVR_DIS_BIT        4
`define RWSM_UVR_LEVEL_LSB      0
`define RWSM_WDT_MODE_LSB       6
`define RWSM_PWR_SAVE_BIT       5
`define RWSM_WDT_CLEAR_BIT      7
`define RWSM_UVD_POL_BIT        7
`define RWSM_UVD_OUT_BIT        6
`define RWSM_UVD_DIS_BIT        4
`define RWSM_UVD_LEVEL_LSB      0
`define RWSM_CFG_POR_DUTY_BIT   5
`define RWSM_CFG_PIN_RST_EN_BIT 7
`define RWSM_SW_RESET_KEY       8'h56
`define RWSM_RST_SUPPLY_CTRL    7'h40
`define RWSM_RST_CONFIG_HIGH    8'hff
`define RWSM_CLK_KHZ            100000
`define RWSM_SLOW_RC_KHZ        75
`define RWSM_WARMUP_MS          40
`define RWSM_WDT_MS_00          220
`define RWSM_WDT_MS_01          110
`define RWSM_WDT_MS_10          55
`define RWSM_WDT_MS_11          27
`define RWSM_PIN_RST_TICKS      2'h2
`endif

// ==== common/rwsm_pkg.sv ====
// Types shared by the reset unit modules.
// Assumes the operating mode is supplied encoded by the core.
package rwsm_pkg;
   typedef enum logic [2:0] {
      RWSM_MODE_FAST = 3'h0,
      RWSM_MODE_SLOW = 3'h1,
      RWSM_MODE_IDLE = 3'h2,
      RWSM_MODE_HALT = 3'h3,
      RWSM_MODE_STOP = 3'h4
   } rwsm_mode_t;
   typedef enum logic [3:0] {
      RWSM_ST_WARMUP = 4'h1,
      RWSM_ST_CFG    = 4'h2,
      RWSM_ST_HOLD   = 4'h4,
      RWSM_ST_RUN    = 4'h8
   } rwsm_seq_t;
   typedef struct packed {
      logic [1:0] wdt_psc;
      logic       uvd_flag;
      logic [6:0] supply_ctrl;
      logic [1:0] wdt_mode;
      logic       pwr_save;
      logic       wdt_clear;
      logic       uvd_pol;
      logic       uvd_dis;
      logic [3:0] uvd_level;
   } rwsm_regs_t;
   typedef struct packed {
      logic por;
      logic pin;
      logic sw;
      logic wdt;
      logic uvr;
   } rwsm_req_t;
   typedef struct packed {
      logic       por_en;
      logic       por_duty8;
      logic       uvr_en;
      logic [3:0] uvr_level;
      logic       uvd_en;
      logic [3:0] uvd_level;
   } rwsm_ctl_t;
endpackage : rwsm_pkg

// ==== src/rwsm_pin_sync.sv ====
// Three-flop synchroniser for one pin; the output moves only when flops two and three agree.
// Assumes the pin is asynchronous to the clock.
`timescale 1ns/100ps
module rwsm_pin_sync #(
   parameter logic P_INIT = 1'b0
) (
   // Clock and reset.
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // Pin and its filtered level.
   input  wire logic i_async,
   output logic      o_level
);
   logic [2:0] sh_q;
   logic [2:0] sh_d;
   logic       lvl_q;
   logic       lvl_d;

   always_comb begin
      sh_d  = {sh_q[1:0], i_async};
      lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sh_q  <= {3{P_INIT}};
         lvl_q <= P_INIT;
      end else begin
         sh_q  <= sh_d;
         lvl_q <= lvl_d;
      end
   end

   assign o_level = lvl_q;
endmodule : rwsm_pin_sync

// ==== src/rwsm_wdt.sv ====
// Watchdog counter advanced by slow-clock ticks, with selectable overflow period.
// Assumes i_tick is a one-cycle pulse per slow-clock rising edge.
`timescale 1ns/100ps
module rwsm_wdt #(
   parameter int P_T00 = 16500,
   parameter int P_T01 = 8250,
   parameter int P_T10 = 4125,
   parameter int P_T11 = 2025
) (
   // Clock and reset.
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // Control.
   input  wire logic       i_clear,
   input  wire logic       i_tick,
   input  wire logic       i_run,
   input  wire logic [1:0] i_psc,
   // One-cycle overflow pulse.
   output logic            o_overflow
);
   localparam logic [14:0] LIM00 = 15'(P_T00 - 1);
   localparam logic [14:0] LIM01 = 15'(P_T01 - 1);
   localparam logic [14:0] LIM10 = 15'(P_T10 - 1);
   localparam logic [14:0] LIM11 = 15'(P_T11 - 1);

   logic [14:0] cnt_q;
   logic [14:0] cnt_d;
   logic [14:0] lim;
   logic        ovf_q;
   logic        ovf_d;

   always_comb begin
      case (i_psc)
         2'h0:    lim = LIM00;
         2'h1:    lim = LIM01;
         2'h2:    lim = LIM10;
         default: lim = LIM11;
      endcase
      cnt_d = cnt_q;
      ovf_d = 1'b0;
      if (i_clear) begin
         cnt_d = 15'h0;
      end else if (i_tick && i_run) begin
         if (cnt_q >= lim) begin
            cnt_d = 15'h0;
            ovf_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 15'h1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_q <= 15'h0;
         ovf_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         ovf_q <= ovf_d;
      end
   end

   assign o_overflow = ovf_q;
endmodule : rwsm_wdt

// ==== src/rwsm_top.sv ====
// Reset unit: merges five reset sources, holds watchdog and supply-monitor controls.
// Assumes an APB master, pins from outside the clock domain and the core's operating mode.
`timescale 1ns/100ps
`include "rwsm_map.svh"

// Functional notes
// - Every reset source returns registers to defaults.
// - Power-on: 40 ms warm-up, then load config.
// - Outside sleep, power-on disable bit gates POR.
// - In halt or stop, second bit gates POR; duty option.
// - Pin reset active low, two slow cycles.
// - Config word enables the pin reset.
// - Writing 56h to 97h resets; others don't.
// - Watchdog mode: off, awake-only, always.
// - Watchdog counts slow clock; sleep per mode.
// - Prescale picks 220, 110, 55, 27 ms.
// - Any reset or clear bit zeroes watchdog.
// - Watchdog clear bit self-clears next cycle.
// - Sixteen reset levels; bit four disables.
// - Power saving drops undervolt reset in sleep.
// - Detector has its own sixteen-level select.
// - Hardware sets detect flag; 7Fh clears it.
// - Flag write zero clears, one keeps.
// - Polarity bit picks detector level for flag.
// - Slow clock nominally 75 kHz.
module rwsm_top #(
   parameter int P_WARMUP_CYCLES = `RWSM_WARMUP_MS * `RWSM_CLK_KHZ,
   parameter int P_WDT_TICKS_00  = `RWSM_WDT_MS_00 * `RWSM_SLOW_RC_KHZ,
   parameter int P_WDT_TICKS_01  = `RWSM_WDT_MS_01 * `RWSM_SLOW_RC_KHZ,
   parameter int P_WDT_TICKS_10  = `RWSM_WDT_MS_10 * `RWSM_SLOW_RC_KHZ,
   parameter int P_WDT_TICKS_11  = `RWSM_WDT_MS_11 * `RWSM_SLOW_RC_KHZ
) (
   // Clock and reset.
   input  wire logic                I_REF_CLK,
   input  wire logic                I_RST_N,
   // APB slave.
   input  wire logic                I_PSEL,
   input  wire logic                I_PENABLE,
   input  wire logic                I_PWRITE,
   input  wire logic [11:0]         I_PADDR,
   input  wire logic [31:0]         I_PWDATA,
   input  wire logic [3:0]          I_PSTRB,
   output logic      [31:0]         O_PRDATA,
   output logic                     O_PREADY,
   output logic                     O_PSLVERR,
   // Pins and analog comparators.
   input  wire logic                I_SLOW_RC_CLOCK,
   input  wire logic                I_EXTERNAL_PIN_RESET_N,
   input  wire logic                I_POR_DETECT,
   input  wire logic                I_UNDERVOLT_RESET_CMP,
   input  wire logic                I_UNDERVOLT_DETECT_OUTPUT,
   // Core state and configuration memory.
   input  wire rwsm_pkg::rwsm_mode_t I_OP_MODE,
   input  wire logic [7:0]          I_CONFIG_WORD_HIGH,
   output logic                     O_CONFIG_WORD_LOAD,
   // Reset and analog controls.
   output logic                     O_SYS_RST_N,
   output logic                     O_POR_ENABLE,
   output logic                     O_POR_DUTY_EIGHTH,
   output logic                     O_UNDERVOLT_RESET_EN,
   output logic      [3:0]          O_UNDERVOLT_RESET_LEVEL,
   output logic                     O_UNDERVOLT_DETECT_EN,
   output logic      [3:0]          O_UNDERVOLT_DETECT_LEVEL,
   output logic                     O_UNDERVOLT_DETECT_FLAG
);
   localparam logic [21:0] WARM_LAST = 22'(P_WARMUP_CYCLES - 1);
   localparam logic [4:0]  SYNC_INIT = 5'h02;

   function automatic logic rwsm_hit(input logic [11:0] addr);
      logic [7:0] idx;
      idx = addr[9:2];
      rwsm_hit = 1'b0;
      if (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) begin
         case (idx)
            `RWSM_IDX_TIMER_ADC_CLK_CFG,
            `RWSM_IDX_AUX_IRQ_FLAGS,
            `RWSM_IDX_SOFT_COMMAND,
            `RWSM_IDX_UNDERVOLT_DETECT_CTL,
            `RWSM_IDX_SUPPLY_MONITOR_CTRL,
            `RWSM_IDX_WATCHDOG_POWER_CTRL,
            `RWSM_IDX_AUX_STROBE_CTRL: rwsm_hit = 1'b1;
            default:                   rwsm_hit = 1'b0;
         endcase
      end
   endfunction : rwsm_hit

   // Synchronised pins.
   logic [4:0] async_in;
   logic [4:0] sync_lvl;
   logic       rc_lvl;
   logic       pin_n;
   logic       por_det;
   logic       uvr_cmp;
   logic       uvd_out;

   assign async_in = {I_UNDERVOLT_DETECT_OUTPUT, I_UNDERVOLT_RESET_CMP, I_POR_DETECT,
                      I_EXTERNAL_PIN_RESET_N, I_SLOW_RC_CLOCK};

   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_sync
         rwsm_pin_sync #(.P_INIT(SYNC_INIT[g])) u_sync (
            .i_clk   (I_REF_CLK),
            .i_rst_n (I_RST_N),
            .i_async (async_in[g]),
            .o_level (sync_lvl[g])
         );
      end
   endgenerate

   assign rc_lvl  = sync_lvl[0];
   assign pin_n   = sync_lvl[1];
   assign por_det = sync_lvl[2];
   assign uvr_cmp = sync_lvl[3];
   assign uvd_out = sync_lvl[4];

   // State.
   rwsm_pkg::rwsm_seq_t  seq_q;
   rwsm_pkg::rwsm_seq_t  seq_d;
   rwsm_pkg::rwsm_regs_t regs_q;
   rwsm_pkg::rwsm_regs_t regs_d;
   rwsm_pkg::rwsm_ctl_t  ctl_q;
   rwsm_pkg::rwsm_ctl_t  ctl_d;
   rwsm_pkg::rwsm_req_t  req;
   logic [21:0] warm_q;
   logic [21:0] warm_d;
   logic        sys_rst_q;
   logic        sys_rst_d;
   logic [7:0]  cfg_q;
   logic [7:0]  cfg_d;
   logic        rc_prev_q;
   logic        slow_tick;
   logic [1:0]  pin_cnt_q;
   logic [1:0]  pin_cnt_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic        slverr_q;
   logic        slverr_d;
   logic        reg_rst;
   logic        sleep;
   logic        power_down_state;
   logic        awake;
   logic        wr_en;
   logic [7:0]  idx;
   logic [7:0]  wbyte;
   logic [7:0]  rd8;
   logic        wdt_ovf;
   logic        wdt_run;
   logic        uvd_cond;

   assign slow_tick = rc_lvl & ~rc_prev_q;
   // A system reset clears the register file just as the reset pin does.
   assign reg_rst = ~I_RST_N | sys_rst_q;
   assign power_down_state   = (I_OP_MODE == rwsm_pkg::RWSM_MODE_HALT) ||
                    (I_OP_MODE == rwsm_pkg::RWSM_MODE_STOP);
   assign sleep   = power_down_state || (I_OP_MODE == rwsm_pkg::RWSM_MODE_IDLE);
   assign awake   = ~sleep;
   assign idx     = I_PADDR[9:2];
   assign wbyte   = I_PWDATA[7:0];
   assign wr_en   = I_PSEL & I_PENABLE & I_PWRITE & I_PSTRB[0] & rwsm_hit(I_PADDR);

   // Watchdog.
   assign wdt_run = awake | (regs_q.wdt_mode == 2'h3);

   rwsm_wdt #(
      .P_T00 (P_WDT_TICKS_00),
      .P_T01 (P_WDT_TICKS_01),
      .P_T10 (P_WDT_TICKS_10),
      .P_T11 (P_WDT_TICKS_11)
   ) u_wdt (
      .i_clk      (I_REF_CLK),
      .i_rst_n    (I_RST_N),
      .i_clear    (reg_rst | regs_q.wdt_clear),
      .i_tick     (slow_tick),
      .i_run      (wdt_run),
      .i_psc      (regs_q.wdt_psc),
      .o_overflow (wdt_ovf)
   );

   // Reset requests.
   always_comb begin
      req.por = por_det & ctl_q.por_en;
      req.pin = cfg_q[`RWSM_CFG_PIN_RST_EN_BIT] & ~pin_n &
                (pin_cnt_q == `RWSM_PIN_RST_TICKS);
      req.sw  = wr_en & (idx == `RWSM_IDX_SOFT_COMMAND) &
                (wbyte == `RWSM_SW_RESET_KEY);
      req.wdt = wdt_ovf & regs_q.wdt_mode[1] &
                (regs_q.wdt_mode[0] | awake);
      req.uvr = uvr_cmp & ctl_q.uvr_en;
   end

   // Pin filter counts slow edges while the pin stays low.
   always_comb begin
      pin_cnt_d = pin_cnt_q;
      if (pin_n) begin
         pin_cnt_d = 2'h0;
      end else if (slow_tick && pin_cnt_q != `RWSM_PIN_RST_TICKS) begin
         pin_cnt_d = pin_cnt_q + 2'h1;
      end
   end

   // Reset sequencer.
   always_comb begin
      seq_d     = seq_q;
      warm_d    = warm_q;
      sys_rst_d = sys_rst_q;
      cfg_d     = cfg_q;
      case (seq_q)
         rwsm_pkg::RWSM_ST_WARMUP: begin
            sys_rst_d = 1'b1;
            if (req.por) begin
               warm_d = 22'h0;
            end else if (warm_q == WARM_LAST) begin
               warm_d = 22'h0;
               seq_d  = rwsm_pkg::RWSM_ST_CFG;
            end else begin
               warm_d = warm_q + 22'h1;
            end
         end
         rwsm_pkg::RWSM_ST_CFG: begin
            cfg_d = I_CONFIG_WORD_HIGH;
            seq_d = rwsm_pkg::RWSM_ST_HOLD;
         end
         rwsm_pkg::RWSM_ST_HOLD: begin
            sys_rst_d = 1'b1;
            if (req.por) begin
               seq_d = rwsm_pkg::RWSM_ST_WARMUP;
            end else if (req == '0 && slow_tick) begin
               seq_d     = rwsm_pkg::RWSM_ST_RUN;
               sys_rst_d = 1'b0;
            end
         end
         rwsm_pkg::RWSM_ST_RUN: begin
            sys_rst_d = 1'b0;
            if (req.por) begin
               seq_d     = rwsm_pkg::RWSM_ST_WARMUP;
               warm_d    = 22'h0;
               sys_rst_d = 1'b1;
            end else if (req != '0) begin
               seq_d     = rwsm_pkg::RWSM_ST_HOLD;
               sys_rst_d = 1'b1;
            end
         end
         default: begin
            seq_d     = rwsm_pkg::RWSM_ST_WARMUP;
            warm_d    = 22'h0;
            sys_rst_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         seq_q     <= rwsm_pkg::RWSM_ST_WARMUP;
         warm_q    <= 22'h0;
         sys_rst_q <= 1'b1;
         cfg_q     <= `RWSM_RST_CONFIG_HIGH;
         rc_prev_q <= 1'b0;
         pin_cnt_q <= 2'h0;
      end else begin
         seq_q     <= seq_d;
         warm_q    <= warm_d;
         sys_rst_q <= sys_rst_d;
         cfg_q     <= cfg_d;
         rc_prev_q <= rc_lvl;
         pin_cnt_q <= pin_cnt_d;
      end
   end

   // Register file and bus answer.
   assign uvd_cond = ctl_q.uvd_en &
                     (regs_q.uvd_pol ? ~uvd_out : uvd_out);

   always_comb begin
      regs_d           = regs_q;
      regs_d.wdt_clear = 1'b0;
      if (wr_en) begin
         case (idx)
            `RWSM_IDX_TIMER_ADC_CLK_CFG: begin
               regs_d.wdt_psc = wbyte[`RWSM_WDT_PSC_LSB +: 2];
            end
            `RWSM_IDX_AUX_IRQ_FLAGS: begin
               if (!wbyte[`RWSM_UVD_FLAG_BIT]) begin
                  regs_d.uvd_flag = 1'b0;
               end
            end
            `RWSM_IDX_UNDERVOLT_DETECT_CTL: begin
               regs_d.uvd_pol   = wbyte[`RWSM_UVD_POL_BIT];
               regs_d.uvd_dis   = wbyte[`RWSM_UVD_DIS_BIT];
               regs_d.uvd_level = wbyte[`RWSM_UVD_LEVEL_LSB +: 4];
            end
            `RWSM_IDX_SUPPLY_MONITOR_CTRL: begin
               regs_d.supply_ctrl = wbyte[6:0];
            end
            `RWSM_IDX_WATCHDOG_POWER_CTRL: begin
               regs_d.wdt_mode = wbyte[`RWSM_WDT_MODE_LSB +: 2];
               regs_d.pwr_save = wbyte[`RWSM_PWR_SAVE_BIT];
            end
            `RWSM_IDX_AUX_STROBE_CTRL: begin
               regs_d.wdt_clear = wbyte[`RWSM_WDT_CLEAR_BIT];
            end
            default: begin
               regs_d = regs_q;
            end
         endcase
      end
      // The hardware set follows the clear, so an event in the clearing cycle survives.
      if (uvd_cond) begin
         regs_d.uvd_flag = 1'b1;
      end
   end

   always_comb begin
      rd8 = 8'h00;
      case (idx)
         `RWSM_IDX_TIMER_ADC_CLK_CFG: rd8[`RWSM_WDT_PSC_LSB +: 2] = regs_q.wdt_psc;
         `RWSM_IDX_AUX_IRQ_FLAGS:     rd8[`RWSM_UVD_FLAG_BIT] = regs_q.uvd_flag;
         `RWSM_IDX_UNDERVOLT_DETECT_CTL: begin
            rd8[`RWSM_UVD_POL_BIT]         = regs_q.uvd_pol;
            rd8[`RWSM_UVD_OUT_BIT]         = uvd_out;
            rd8[`RWSM_UVD_DIS_BIT]         = regs_q.uvd_dis;
            rd8[`RWSM_UVD_LEVEL_LSB +: 4] = regs_q.uvd_level;
         end
         `RWSM_IDX_SUPPLY_MONITOR_CTRL: rd8[6:0] = regs_q.supply_ctrl;
         `RWSM_IDX_WATCHDOG_POWER_CTRL: begin
            rd8[`RWSM_WDT_MODE_LSB +: 2] = regs_q.wdt_mode;
            rd8[`RWSM_PWR_SAVE_BIT]      = regs_q.pwr_save;
         end
         `RWSM_IDX_AUX_STROBE_CTRL: rd8[`RWSM_WDT_CLEAR_BIT] = regs_q.wdt_clear;
         default: rd8 = 8'h00;
      endcase
      prdata_d = prdata_q;
      slverr_d = slverr_q;
      // Read data is sampled in the setup phase so that the access phase never waits.
      if (I_PSEL && !I_PENABLE) begin
         prdata_d = {24'h000000, rwsm_hit(I_PADDR) ? rd8 : 8'h00};
         slverr_d = ~rwsm_hit(I_PADDR);
      end
   end

   // Analog controls, registered so the pins never glitch on mode changes.
   always_comb begin
      ctl_d           = ctl_q;
      ctl_d.por_en    = ~regs_q.supply_ctrl[`RWSM_POR_DIS_BIT] &
                        ~(power_down_state & regs_q.supply_ctrl[`RWSM_SLEEP_POR_DIS_BIT]);
      ctl_d.por_duty8 = power_down_state & ctl_d.por_en & cfg_q[`RWSM_CFG_POR_DUTY_BIT];
      ctl_d.uvr_en    = ~regs_q.supply_ctrl[`RWSM_UVR_DIS_BIT] &
                        ~(sleep & regs_q.pwr_save);
      ctl_d.uvr_level = regs_q.supply_ctrl[`RWSM_UVR_LEVEL_LSB +: 4];
      ctl_d.uvd_en    = ~regs_q.uvd_dis & awake;
      ctl_d.uvd_level = regs_q.uvd_level;
   end

   always_ff @(posedge I_REF_CLK) begin
      if (reg_rst) begin
         regs_q             <= '0;
         regs_q.supply_ctrl <= `RWSM_RST_SUPPLY_CTRL;
         ctl_q              <= '0;
         ctl_q.por_en       <= 1'b1;
         ctl_q.uvr_en       <= 1'b1;
      end else begin
         regs_q <= regs_d;
         ctl_q  <= ctl_d;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         prdata_q <= 32'h00000000;
         slverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         slverr_q <= slverr_d;
      end
   end

   // Outputs.
   assign O_PRDATA                 = prdata_q;
   assign O_PREADY                 = I_PSEL & I_PENABLE;
   assign O_PSLVERR                = I_PSEL & I_PENABLE & slverr_q;
   assign O_CONFIG_WORD_LOAD       = (seq_q == rwsm_pkg::RWSM_ST_CFG);
   assign O_SYS_RST_N              = ~sys_rst_q;
   assign O_POR_ENABLE             = ctl_q.por_en;
   assign O_POR_DUTY_EIGHTH        = ctl_q.por_duty8;
   assign O_UNDERVOLT_RESET_EN     = ctl_q.uvr_en;
   assign O_UNDERVOLT_RESET_LEVEL  = ctl_q.uvr_level;
   assign O_UNDERVOLT_DETECT_EN    = ctl_q.uvd_en;
   assign O_UNDERVOLT_DETECT_LEVEL = ctl_q.uvd_level;
   assign O_UNDERVOLT_DETECT_FLAG  = regs_q.uvd_flag;
endmodule : rwsm_top

// ==== test/rwsm_chk.sv ====
// Concurrent checks on the reset unit, seeing only its top-level ports.
// Assumes one clock domain and the synchronous active-low reset input.
`timescale 1ns/100ps
module rwsm_chk (
   // Clock, reset and bus.
   input wire logic        I_REF_CLK,
   input wire logic        I_RST_N,
   input wire logic        I_PSEL,
   input wire logic        I_PENABLE,
   input wire logic        I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [3:0]  I_PSTRB,
   input wire logic [31:0] O_PRDATA,
   input wire logic        O_PREADY,
   // Sources, mode and reset outputs.
   input wire logic        I_POR_DETECT,
   input wire logic        I_UNDERVOLT_RESET_CMP,
   input wire logic [2:0]  I_OP_MODE,
   input wire logic        O_CONFIG_WORD_LOAD,
   input wire logic        O_SYS_RST_N,
   input wire logic        O_POR_ENABLE,
   input wire logic        O_POR_DUTY_EIGHTH,
   input wire logic        O_UNDERVOLT_RESET_EN,
   input wire logic        O_UNDERVOLT_DETECT_EN
);
   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (!I_RST_N);
   sequence s_setup;
      I_PSEL && !I_PENABLE;
   endsequence
   sequence s_key_write;
      I_PSEL && I_PENABLE && I_PWRITE && I_PSTRB[0] && I_PADDR == 12'h25c
         && I_PWDATA[7:0] == 8'h56;
   endsequence
   a_bus_ready_zero: assert property (
      s_setup ##1 I_PSEL && I_PENABLE |-> O_PREADY && O_PRDATA[31:8] == 24'h000000)
      else $error("no ready or upper data set");
   a_soft_key_reset: assert property (
      s_key_write ##0 O_SYS_RST_N |-> ##1 !O_SYS_RST_N)
      else $error("no reset after key");
   a_cfg_load_pulse: assert property (
      $rose(O_CONFIG_WORD_LOAD) |=> !O_CONFIG_WORD_LOAD)
      else $error("long config load");
   a_cfg_in_reset: assert property (
      O_CONFIG_WORD_LOAD |-> !O_SYS_RST_N ##1 !O_SYS_RST_N)
      else $error("load outside reset");
   a_duty_sleep_only: assert property (
      O_POR_DUTY_EIGHTH |-> $past(I_OP_MODE) inside
         {rwsm_pkg::RWSM_MODE_HALT, rwsm_pkg::RWSM_MODE_STOP})
      else $error("duty while awake");
   a_detect_awake: assert property (
      O_UNDERVOLT_DETECT_EN |-> $past(I_OP_MODE) <= rwsm_pkg::RWSM_MODE_SLOW)
      else $error("detector enabled in sleep");
   a_uv_reset_hold: assert property (
      (I_UNDERVOLT_RESET_CMP && O_UNDERVOLT_RESET_EN) [*8] |-> !O_SYS_RST_N)
      else $error("undervolt held without reset");
   a_por_reset_hold: assert property (
      (I_POR_DETECT && O_POR_ENABLE) [*8] |-> !O_SYS_RST_N)
      else $error("power-on held without reset");
endmodule : rwsm_chk
bind rwsm_top rwsm_chk i_rwsm_chk (.*);

// ==== test/testbench.sv ====
// Bench for the reset unit: register rows in a loop, then each reset source.
// The slow clock runs far above nominal to keep the run short.
`timescale 1ns/100ps
module testbench;
   typedef struct packed {
      logic        w;
      logic [11:0] a;
      logic [7:0]  d;
      logic [7:0]  e;
      logic        r;
   } rwsm_row_t;
   logic                 clk = 1'b0;
   logic                 src = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 psel = 1'b0;
   logic                 pen = 1'b0;
   logic                 pwr = 1'b0;
   logic [11:0]          paddr = 12'h000;
   logic [31:0]          pwdata = 32'h0;
   logic                 pin_n = 1'b1;
   logic                 por = 1'b0;
   logic                 cmp = 1'b0;
   logic                 uvo = 1'b0;
   logic [3:0]           pstrb = 4'hf;
   logic [7:0]           config_word = 8'hff;
   rwsm_pkg::rwsm_mode_t mode = rwsm_pkg::RWSM_MODE_FAST;
   logic [31:0]          prdata, rd;
   logic [3:0]           uvr_lvl, uvd_lvl;
   logic                 pready, pslverr, cfg_load, sys_rst_n, por_en, duty, err;
   logic                 uvr_en, uvd_en, uvd_flag;
   int                   failures = 0;
   int                   n_compared = 0;
   int                   waited;
   rwsm_row_t            rows [17] = '{
      '{1'h0, 12'h250, 8'h00, 8'h00, 1'h0}, '{1'h0, 12'h254, 8'h00, 8'h00, 1'h0},
      '{1'h0, 12'h2fc, 8'h00, 8'h00, 1'h0}, '{1'h0, 12'h38c, 8'h00, 8'h40, 1'h0},
      '{1'h0, 12'h3dc, 8'h00, 8'h00, 1'h0}, '{1'h0, 12'h3e0, 8'h00, 8'h00, 1'h0},
      '{1'h1, 12'h250, 8'hff, 8'h30, 1'h0}, '{1'h1, 12'h3dc, 8'h20, 8'h20, 1'h0},
      '{1'h1, 12'h38c, 8'h3a, 8'h3a, 1'h0}, '{1'h1, 12'h2fc, 8'h85, 8'h85, 1'h0},
      '{1'h0, 12'h254, 8'h00, 8'h80, 1'h0}, '{1'h1, 12'h254, 8'h7f, 8'h80, 1'h0},
      '{1'h1, 12'h2fc, 8'h05, 8'h05, 1'h0}, '{1'h1, 12'h254, 8'hff, 8'h80, 1'h0},
      '{1'h1, 12'h254, 8'h7f, 8'h00, 1'h0}, '{1'h1, 12'h25c, 8'h12, 8'h00, 1'h0},
      '{1'h1, 12'h100, 8'hff, 8'h00, 1'h1}};
   always #5 clk = ~clk;
   always #100 src = ~src;
   rwsm_top #(.P_WARMUP_CYCLES(50), .P_WDT_TICKS_00(8), .P_WDT_TICKS_01(6),
      .P_WDT_TICKS_10(4), .P_WDT_TICKS_11(3)) i_rwsm_top (
      .I_REF_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SLOW_RC_CLOCK(src),
      .I_EXTERNAL_PIN_RESET_N(pin_n), .I_POR_DETECT(por), .I_UNDERVOLT_RESET_CMP(cmp),
      .I_UNDERVOLT_DETECT_OUTPUT(uvo), .I_OP_MODE(mode), .I_CONFIG_WORD_HIGH(config_word),
      .O_CONFIG_WORD_LOAD(cfg_load), .O_SYS_RST_N(sys_rst_n), .O_POR_ENABLE(por_en),
      .O_POR_DUTY_EIGHTH(duty), .O_UNDERVOLT_RESET_EN(uvr_en),
      .O_UNDERVOLT_RESET_LEVEL(uvr_lvl), .O_UNDERVOLT_DETECT_EN(uvd_en),
      .O_UNDERVOLT_DETECT_LEVEL(uvd_lvl), .O_UNDERVOLT_DETECT_FLAG(uvd_flag));
   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      pen    <= 1'b1;
      waited = 0;
      do begin
         @(posedge clk);
         waited++;
      end while (pready !== 1'b1 && waited < 16);
      rd   = prdata;
      err  = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
      chk("bus_wait", {31'h0, waited >= 16}, 32'h0);
      if (waited >= 16) report_and_stop();
   endtask : apb
   // A hang would stall every later test.
   task wait_for(input logic sel, input logic lvl, input int lim);
      waited = 0;
      while ((sel ? cfg_load : sys_rst_n) !== lvl && waited < lim) begin
         @(posedge clk);
         waited++;
      end
      chk("wait", {31'h0, waited >= lim}, 32'h0);
      if (waited >= lim) report_and_stop();
   endtask : wait_for
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      wait_for(1'b1, 1'b1, 200);
      chk("warmup", {31'h0, waited >= 48 && waited <= 53}, 32'h1);
      wait_for(1'b0, 1'b1, 3000);
      for (int i = 0; i < 17; i++) begin
         if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 8'h00);
         chk("rdata", rd, {24'h0, rows[i].e});
         chk("slverr", {31'h0, err}, {31'h0, rows[i].r});
      end
      chk("uvr_lvl", {28'h0, uvr_lvl}, 32'ha);
      chk("uvr_en", {31'h0, uvr_en}, 32'h0);
      chk("por_en", {31'h0, por_en}, 32'h0);
      chk("uvd_lvl", {28'h0, uvd_lvl}, 32'h5);
      uvo <= 1'b1;
      repeat (8) @(posedge clk);
      chk("uvd_flag", {31'h0, uvd_flag}, 32'h1);
      $display("test registers done");
      apb(1'b1, 12'h38c, 8'h0a);
      mode <= rwsm_pkg::RWSM_MODE_HALT;
      repeat (4) @(posedge clk);
      chk("duty", {31'h0, duty}, 32'h1);
      chk("sleep_por", {31'h0, por_en}, 32'h1);
      chk("sleep_uvr", {31'h0, uvr_en}, 32'h0);
      apb(1'b1, 12'h38c, 8'h4a);
      repeat (3) @(posedge clk);
      chk("sleep_por_off", {31'h0, por_en}, 32'h0);
      mode <= rwsm_pkg::RWSM_MODE_FAST;
      repeat (3) @(posedge clk);
      chk("awake_uvr", {31'h0, uvr_en}, 32'h1);
      chk("awake_por", {31'h0, por_en}, 32'h1);
      $display("test sleep done");
      apb(1'b1, 12'h250, 8'h30);
      apb(1'b1, 12'h3e0, 8'h80);
      apb(1'b0, 12'h3e0, 8'h00);
      chk("wdt_clear", rd, 32'h0);
      mode <= rwsm_pkg::RWSM_MODE_IDLE;
      apb(1'b1, 12'h3dc, 8'h80);
      repeat (150) @(posedge clk);
      chk("idle_wdt", {31'h0, sys_rst_n}, 32'h1);
      mode <= rwsm_pkg::RWSM_MODE_FAST;
      wait_for(1'b0, 1'b0, 100);
      wait_for(1'b0, 1'b1, 3000);
      $display("test watchdog done");
      apb(1'b1, 12'h38c, 8'h0f);
      apb(1'b1, 12'h25c, 8'h56);
      wait_for(1'b0, 1'b0, 4);
      wait_for(1'b0, 1'b1, 3000);
      apb(1'b0, 12'h38c, 8'h00);
      chk("soft_default", rd, 32'h40);
      pin_n <= 1'b0;
      repeat (15) @(posedge clk);
      pin_n <= 1'b1;
      repeat (60) @(posedge clk);
      chk("short_pin", {31'h0, sys_rst_n}, 32'h1);
      pin_n <= 1'b0;
      wait_for(1'b0, 1'b0, 100);
      pin_n <= 1'b1;
      wait_for(1'b0, 1'b1, 3000);
      cmp <= 1'b1;
      wait_for(1'b0, 1'b0, 40);
      repeat (10) @(posedge clk);
      cmp <= 1'b0;
      wait_for(1'b0, 1'b1, 3000);
      por <= 1'b1;
      repeat (20) @(posedge clk);
      por <= 1'b0;
      wait_for(1'b1, 1'b1, 200);
      wait_for(1'b0, 1'b1, 3000);
      $display("test sources done");
      report_and_stop();
   end
endmodule : testbench
